/* rtl/dlc_display_control.sv */
// display enable, layer attributes, flash timing and cursor stepping
`timescale 1ns/1ps
`default_nettype none
module dlc_display_control
  import dlc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire dlc_regbus_t regBus,
  output logic [7:0] regRdata,
  input wire dlc_cmd_t switchCmd,
  input wire logic powerSaveEnter,
  input wire logic dualPanel,
  input wire logic frameStart,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic cursorLoad,
  input wire logic [ADDR_W-1:0] cursorLoadAddr,
  output logic displayOn,
  output dlc_vis_t visible,
  output logic [ADDR_W-1:0] cursorAddr,
  output logic [7:0] attrOut
);

  typedef struct packed {
    logic enable;
    dlc_attr_t attr;
    logic [ADDR_W-1:0] cursorPos;
    dlc_vis_t vis;
    logic [7:0] rdata;
  } dlc_state_t;

  dlc_state_t st_r;
  dlc_state_t st_nxt;
  logic [DLC_FRAME_CNT_W-1:0] frameCnt;

  localparam logic [DLC_FRAME_CNT_W-1:0] BLK_SLOW_MASK =
    DLC_FRAME_CNT_W'(DLC_BLOCK_SLOW_DIV - 1);
  localparam logic [DLC_FRAME_CNT_W-1:0] BLK_FAST_MASK =
    DLC_FRAME_CNT_W'(DLC_BLOCK_FAST_DIV - 1);
  localparam logic [DLC_FRAME_CNT_W-1:0] CUR_SLOW_MASK =
    DLC_FRAME_CNT_W'(DLC_CURSOR_SLOW_DIV - 1);
  localparam logic [DLC_FRAME_CNT_W-1:0] CUR_FAST_MASK =
    DLC_FRAME_CNT_W'(DLC_CURSOR_FAST_DIV - 1);
  localparam logic [DLC_FRAME_CNT_W-1:0] CUR_SLOW_ON = DLC_FRAME_CNT_W'(DLC_CURSOR_SLOW_ON);
  localparam logic [DLC_FRAME_CNT_W-1:0] CUR_FAST_ON = DLC_FRAME_CNT_W'(DLC_CURSOR_FAST_ON);

  dlc_frame_counter #(
    .CNT_W(DLC_FRAME_CNT_W)
  ) uFrameCounter (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .frameStart(frameStart),
    .frameCnt(frameCnt)
  );

  // blocks flash with an even duty: lit for the first half of each period
  function automatic logic blockVisible(input logic [1:0] field,
                                        input logic [DLC_FRAME_CNT_W-1:0] cnt);
    logic [DLC_FRAME_CNT_W-1:0] ph;
    ph = '0;
    blockVisible = 1'b0;
    case (field)
      DLC_VIS_BLANK: blockVisible = 1'b0;
      DLC_VIS_STEADY: blockVisible = 1'b1;
      DLC_VIS_SLOW: begin
        ph = cnt & BLK_SLOW_MASK;
        blockVisible = (ph < DLC_FRAME_CNT_W'(DLC_BLOCK_SLOW_DIV / 2));
      end
      DLC_VIS_FAST: begin
        ph = cnt & BLK_FAST_MASK;
        blockVisible = (ph < DLC_FRAME_CNT_W'(DLC_BLOCK_FAST_DIV / 2));
      end
      default: blockVisible = 1'b0;
    endcase
  endfunction

  function automatic logic cursorVisible(input logic [1:0] field,
                                         input logic [DLC_FRAME_CNT_W-1:0] cnt);
    cursorVisible = 1'b0;
    case (field)
      DLC_VIS_BLANK: cursorVisible = 1'b0;
      DLC_VIS_STEADY: cursorVisible = 1'b1;
      DLC_VIS_SLOW: cursorVisible = ((cnt & CUR_SLOW_MASK) < CUR_SLOW_ON);
      DLC_VIS_FAST: cursorVisible = ((cnt & CUR_FAST_MASK) < CUR_FAST_ON);
      default: cursorVisible = 1'b0;
    endcase
  endfunction

  function automatic logic hitAddr(input dlc_regbus_t bus, input logic [15:0] addr);
    hitAddr = (bus.addr == addr);
  endfunction

  dlc_attr_t attrAfterHost;
  logic [DLC_FRAME_CNT_W-1:0] nextCnt;

  always_comb begin
    st_nxt = st_r;
    attrAfterHost = st_r.attr;
    // the phase for the frame now starting is the count after this pulse
    nextCnt = frameCnt + 1'b1;

    // master enable: power save entry beats any set in the same cycle
    if (regBus.wr && hitAddr(regBus, DLC_ADDR_ENABLE)) begin
      st_nxt.enable = regBus.wdata[DLC_ENABLE_BIT];
    end
    if (switchCmd.strobe) begin
      st_nxt.enable = switchCmd.displayOn;
    end
    if (powerSaveEnter) begin
      st_nxt.enable = 1'b0;
    end

    if (regBus.wr && hitAddr(regBus, DLC_ADDR_ATTR)) begin
      attrAfterHost = dlc_attr_t'(regBus.wdata);
    end
    if (switchCmd.strobe) begin
      attrAfterHost = dlc_attr_t'(switchCmd.param);
    end
    st_nxt.attr = attrAfterHost;
    // a write to memory wakes a blanked cursor in steady mode
    if (memWrite && attrAfterHost.cursor == DLC_VIS_BLANK) begin
      st_nxt.attr.cursor = DLC_VIS_STEADY;
    end

    if (cursorLoad) begin
      st_nxt.cursorPos = cursorLoadAddr;
    end else if (memWrite || memRead) begin
      st_nxt.cursorPos = st_r.cursorPos + 1'b1;
    end

    // visibility only moves at frame start so mid frame a layer changes only with the master enable
    if (frameStart) begin
      st_nxt.vis.first = blockVisible(st_r.attr.first, nextCnt);
      st_nxt.vis.second = blockVisible(st_r.attr.second, nextCnt);
      st_nxt.vis.third = blockVisible(st_r.attr.third, nextCnt);
      st_nxt.vis.fourth = dualPanel && blockVisible(st_r.attr.second, nextCnt);
      st_nxt.vis.cursor = cursorVisible(st_r.attr.cursor, nextCnt);
    end

    st_nxt.rdata = 8'h00;
    if (regBus.rd) begin
      if (hitAddr(regBus, DLC_ADDR_ENABLE)) begin
        st_nxt.rdata = {7'h00, st_r.enable};
      end else if (hitAddr(regBus, DLC_ADDR_ATTR)) begin
        st_nxt.rdata = st_r.attr;
      end
    end else begin
      st_nxt.rdata = st_r.rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.enable <= DLC_ENABLE_RST[DLC_ENABLE_BIT];
      st_r.attr <= dlc_attr_t'(DLC_ATTR_RST);
      st_r.cursorPos <= '0;
      st_r.vis <= '0;
      st_r.rdata <= 8'h00;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign displayOn = st_r.enable;
  // the master bit masks every layer and the cursor at once
  assign visible = st_r.enable ? st_r.vis : '0;
  assign cursorAddr = st_r.cursorPos;
  assign attrOut = st_r.attr;
  assign regRdata = st_r.rdata;

endmodule
`default_nettype wire

/* rtl/dlc_pkg.sv */
// package for the display layer and cursor control block
package dlc_pkg;

  localparam logic [15:0] DLC_ADDR_ENABLE = 16'h8009;
  localparam logic [15:0] DLC_ADDR_ATTR = 16'h800a;
  localparam int DLC_ENABLE_BIT = 0;
  localparam logic [7:0] DLC_ENABLE_RST = 8'h00;
  localparam logic [7:0] DLC_ATTR_RST = 8'h00;

  localparam int DLC_THIRD_LSB = 6;
  localparam int DLC_SECOND_LSB = 4;
  localparam int DLC_FIRST_LSB = 2;
  localparam int DLC_CURSOR_LSB = 0;

  localparam logic [1:0] DLC_VIS_BLANK = 2'h0;
  localparam logic [1:0] DLC_VIS_STEADY = 2'h1;
  localparam logic [1:0] DLC_VIS_SLOW = 2'h2;
  localparam logic [1:0] DLC_VIS_FAST = 2'h3;

  // flash periods in frames, and the cursor duty in percent
  localparam int DLC_BLOCK_SLOW_DIV = 32;
  localparam int DLC_BLOCK_FAST_DIV = 4;
  localparam int DLC_CURSOR_SLOW_DIV = 32;
  localparam int DLC_CURSOR_FAST_DIV = 64;
  localparam int DLC_CURSOR_DUTY_PCT = 70;
  // visible frames per cursor period, rounded down
  localparam int DLC_CURSOR_SLOW_ON = (DLC_CURSOR_SLOW_DIV * DLC_CURSOR_DUTY_PCT) / 100;
  localparam int DLC_CURSOR_FAST_ON = (DLC_CURSOR_FAST_DIV * DLC_CURSOR_DUTY_PCT) / 100;
  localparam int DLC_FRAME_CNT_W = 6;

  typedef struct packed {
    logic [1:0] third;
    logic [1:0] second;
    logic [1:0] first;
    logic [1:0] cursor;
  } dlc_attr_t;

  typedef struct packed {
    logic cursor;
    logic fourth;
    logic third;
    logic second;
    logic first;
  } dlc_vis_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dlc_regbus_t;

  typedef struct packed {
    logic strobe;
    logic displayOn;
    logic [7:0] param;
  } dlc_cmd_t;

endpackage

/* rtl/dlc_frame_counter.sv */
// free-running frame counter that paces all flashing
`timescale 1ns/1ps
`default_nettype none
module dlc_frame_counter
  import dlc_pkg::*;
#(
  parameter int CNT_W = DLC_FRAME_CNT_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic frameStart,
  output logic [CNT_W-1:0] frameCnt
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } dlc_fc_state_t;

  dlc_fc_state_t st_r;
  dlc_fc_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (frameStart) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign frameCnt = st_r.cnt;

endmodule
`default_nettype wire

/* verif/dlc_monitor.sv */
// assertion checker for the display control block
`timescale 1ns/1ps
`default_nettype none
module dlc_monitor
  import dlc_pkg::*;
#(parameter int ADDR_W = 16) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire dlc_regbus_t regBus,
  input wire logic [7:0] regRdata,
  input wire dlc_cmd_t switchCmd,
  input wire logic powerSaveEnter,
  input wire logic dualPanel,
  input wire logic frameStart,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic cursorLoad,
  input wire logic displayOn,
  input wire dlc_vis_t visible,
  input wire logic [ADDR_W-1:0] cursorAddr,
  input wire logic [7:0] attrOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence sMem;
    clkEn && (memWrite || memRead) && !cursorLoad;
  endsequence
  sequence sQuietW;
    clkEn && memWrite && attrOut[1:0] == 2'h0 && !switchCmd.strobe && !regBus.wr;
  endsequence
  AST_OFF: assert property (!displayOn |-> visible == 5'h00)
    else $error("layer shown while display off");
  AST_PS: assert property (clkEn && powerSaveEnter |=> !displayOn)
    else $error("power save left display on");
  AST_EN: assert property (clkEn && regBus.wr && regBus.addr == DLC_ADDR_ENABLE
    && !switchCmd.strobe && !powerSaveEnter |=> displayOn == $past(regBus.wdata[0]))
    else $error("enable write lost");
  AST_RD: assert property (clkEn && regBus.rd && regBus.addr == DLC_ADDR_ENABLE
    |=> regRdata == {7'h00, $past(displayOn)}) else $error("enable read wrong");
  AST_CMD: assert property (clkEn && switchCmd.strobe && !powerSaveEnter
    |=> attrOut == $past(switchCmd.param) && displayOn == $past(switchCmd.displayOn))
    else $error("switch command not loaded");
  AST_ADV: assert property (sMem |=> cursorAddr == $past(cursorAddr) + 1'b1)
    else $error("cursor did not advance");
  AST_AUTO: assert property (sQuietW |=> attrOut[1:0] == DLC_VIS_STEADY)
    else $error("cursor not auto enabled");
  AST_RDKEEP: assert property (clkEn && memRead && !memWrite && !switchCmd.strobe
    && !regBus.wr |=> $stable(attrOut)) else $error("read changed attributes");
  AST_HOLD: assert property (clkEn && !frameStart && displayOn
    |=> !displayOn || $stable(visible)) else $error("visibility changed mid frame");
  AST_DUAL: assert property (clkEn && frameStart && !dualPanel |=> !visible.fourth)
    else $error("fourth block shown in single panel");
endmodule
bind dlc_display_control dlc_monitor #(.ADDR_W(ADDR_W)) dlc_monitor_i (.*);
`default_nettype wire

/* verif/dlc_host_model.sv */
// host model: register writes, reads and the switch command
`timescale 1ns/1ps
`default_nettype none
module dlc_host_model
  import dlc_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] regRdata,
  output dlc_regbus_t regBus,
  output dlc_cmd_t switchCmd
);
  initial begin
    regBus = '0;
    switchCmd = '0;
  end
  // released lines show the inverse so a stale value never passes
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    regBus = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    regBus = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    regBus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    regBus = '{1'b0, 1'b0, ~a, 8'hff};
    d = regRdata;
  endtask
  task automatic cmd(input logic on, input logic [7:0] p);
    @(negedge clock);
    switchCmd = '{1'b1, on, p};
    @(negedge clock);
    switchCmd = '{1'b0, ~on, ~p};
  endtask
endmodule
`default_nettype wire

/* verif/dlc_tb_top.sv */
// testbench top for the display control block
`timescale 1ns/1ps
`default_nettype none
module display_layer_cursor_control_tb_top
  import dlc_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic powerSaveEnter = 1'b0;
  logic dualPanel = 1'b0;
  logic frameStart = 1'b0;
  logic memWrite = 1'b0;
  logic memRead = 1'b0;
  logic cursorLoad = 1'b0;
  logic [15:0] cursorLoadAddr = 16'h0010;
  dlc_regbus_t regBus;
  dlc_cmd_t switchCmd;
  logic [7:0] regRdata, attrOut, rdv;
  logic displayOn;
  dlc_vis_t visible;
  logic [15:0] cursorAddr;
  logic [1:0] c;
  int error_cnt = 0;
  int n_compared = 0;
  int fc = 0;
  dlc_display_control dlc_display_control_i (.*);
  dlc_host_model dlc_host_model_i (.*);
  initial forever #2 clock = ~clock;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic ev(input logic [1:0] k, input int n, input bit cur);
    case (k)
      2'h0: return 1'b0;
      2'h1: return 1'b1;
      2'h2: return (n % 32) < (cur ? 22 : 16);
      default: return cur ? (n % 64) < 44 : (n % 4) < 2;
    endcase
  endfunction
  // fc mirrors the six bit frame count, wrapping at 64
  task automatic frame;
    @(negedge clock);
    frameStart = 1'b1;
    fc = (fc + 1) % 64;
    @(negedge clock);
    frameStart = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic mem(input logic w, input logic r, input logic l);
    @(negedge clock);
    {memWrite, memRead, cursorLoad} = {w, r, l};
    @(negedge clock);
    {memWrite, memRead, cursorLoad} = 3'h0;
  endtask
  initial begin
    #60000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    dlc_host_model_i.rd(DLC_ADDR_ENABLE, rdv); chk("enable", 8'h00, rdv);
    dlc_host_model_i.rd(DLC_ADDR_ATTR, rdv); chk("attr", 8'h00, rdv);
    dlc_host_model_i.rd(16'h8008, rdv); chk("unmapped", 8'h00, rdv);
    dlc_host_model_i.wr(DLC_ADDR_ENABLE, 8'hff);
    dlc_host_model_i.rd(DLC_ADDR_ENABLE, rdv); chk("enable", 8'h01, rdv);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      dualPanel = c[0];
      dlc_host_model_i.wr(DLC_ADDR_ATTR, {c, c, c, c});
      repeat (64) begin
        frame();
        chk("visible", {ev(c, fc, 1), dualPanel & ev(c, fc, 0), {3{ev(c, fc, 0)}}},
          visible);
      end
    end
    dlc_host_model_i.cmd(1'b1, 8'h55);
    chk("attrOut", 8'h55, attrOut);
    dlc_host_model_i.rd(DLC_ADDR_ATTR, rdv); chk("attr", 8'h55, rdv);
    frame();
    chk("visible", 5'h1f, visible);
    dlc_host_model_i.wr(DLC_ADDR_ENABLE, 8'h00);
    chk("visible", 5'h00, visible);
    dlc_host_model_i.cmd(1'b1, 8'h55);
    mem(1'b0, 1'b0, 1'b0);
    powerSaveEnter = 1'b1;
    @(negedge clock);
    powerSaveEnter = 1'b0;
    chk("displayOn", 1'b0, displayOn);
    dlc_host_model_i.wr(DLC_ADDR_ATTR, 8'h00);
    mem(1'b0, 1'b0, 1'b1);
    mem(1'b1, 1'b0, 1'b0);
    chk("attrOut", 8'h01, attrOut);
    chk("cursorAddr", 16'h0011, cursorAddr);
    dlc_host_model_i.wr(DLC_ADDR_ATTR, 8'h00);
    mem(1'b0, 1'b1, 1'b0);
    chk("attrOut", 8'h00, attrOut);
    chk("cursorAddr", 16'h0012, cursorAddr);
    // a low clock enable must freeze the cursor and the attributes
    @(negedge clock);
    clkEn = 1'b0;
    mem(1'b1, 1'b0, 1'b0);
    chk("cursorAddr", 16'h0012, cursorAddr);
    chk("attrOut", 8'h00, attrOut);
    clkEn = 1'b1;
    mem(1'b1, 1'b0, 1'b0);
    chk("cursorAddr", 16'h0013, cursorAddr);
    give_verdict();
  end
endmodule
`default_nettype wire
